/* File: rtl/fcq_pkg.sv */
// constants for the parallel flash command and query controller
package fcq_pkg;
  localparam int          FCQ_AW       = 22;
  localparam int          FCQ_DW       = 16;
  // unlock and command addresses (low address lines only)
  localparam logic [21:0] ADR_UNLOCK1  = 22'h000555;
  localparam logic [21:0] ADR_UNLOCK2  = 22'h0002aa;
  localparam logic [21:0] ADR_QUERY    = 22'h000055;
  localparam logic [21:0] ADR_ZERO     = 22'h000000;
  // command data; upper byte always driven low
  localparam logic [15:0] DAT_UNLOCK1  = 16'h00aa;
  localparam logic [15:0] DAT_UNLOCK2  = 16'h0055;
  localparam logic [15:0] DAT_BUF_LOAD = 16'h0025;
  localparam logic [15:0] DAT_BUF_CONF = 16'h0029;
  localparam logic [15:0] DAT_KEY_CNT  = 16'h0003;
  localparam logic [15:0] DAT_PROGRAM  = 16'h00a0;
  localparam logic [15:0] DAT_GLB_ENT  = 16'h0050;
  localparam logic [15:0] DAT_MODE_EX1 = 16'h0090;
  localparam logic [15:0] DAT_PERM_LCK = 16'h0087;
  localparam logic [15:0] DAT_QRY_ENT  = 16'h0098;
  localparam logic [15:0] DAT_ID_EXIT  = 16'h00f0;
  // buffered programming limits
  localparam logic [4:0]  BUF_MAX_WORDS = 5'h10;
  localparam int          BUF_WC_MAX    = 15;
  // sequence lengths in bus cycles, and step numbers within the permanent lock sequence
  localparam logic [4:0]  LEN_SINGLE   = 5'h01;
  localparam logic [4:0]  LEN_BUF_XTRA = 5'h05;
  localparam logic [4:0]  LEN_KEY_PROG = 5'h08;
  localparam logic [4:0]  LEN_KEY_SUB  = 5'h07;
  localparam logic [4:0]  LEN_PERM     = 5'h0a;
  localparam logic [4:0]  LEN_QUERY    = 5'h03;
  localparam logic [4:0]  STEP_GLB_RD  = 5'h03;
  localparam logic [4:0]  STEP_GLB_EX  = 5'h05;
  // bus timing at 20 MHz
  localparam int          CLK_NS       = 50;
  localparam int          T_WP_NS      = 40;
  localparam int          T_ACC_NS     = 70;
  localparam int          SYNC_STAGES  = 2;
  localparam int          WP_CYC_I     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          ACC_CYC_I    = (T_ACC_NS + CLK_NS - 1) / CLK_NS
                                         + SYNC_STAGES;
  localparam logic [3:0]  WP_CYC       = 4'(WP_CYC_I < 1 ? 1 : WP_CYC_I);
  localparam logic [3:0]  ACC_CYC      = 4'(ACC_CYC_I);

  typedef enum logic [2:0] {
    FCQ_OP_READ, FCQ_OP_WRITE, FCQ_OP_BUF_PROG, FCQ_OP_KEY_PROG,
    FCQ_OP_KEY_SUBMIT, FCQ_OP_PERM_LOCK, FCQ_OP_QUERY, FCQ_OP_ID_EXIT
  } fcq_op_t;

  typedef enum logic [2:0] {
    FCQ_IDLE, FCQ_FETCH, FCQ_SETUP, FCQ_STROBE, FCQ_RECOVER, FCQ_DONE
  } fcq_state_t;
endpackage

/* File: rtl/fcq_host.sv */
// host-side sequencer driving a parallel flash through its pins
`timescale 1ns/100ps
//
// Behaviour
// - upper data byte driven low in commands
// - buffered words share A21-A4 with first
// - word count is words minus one, max 15
// - boot blocks addressed by own block address
// - full two-cycle program per key portion
// - key portions accepted in any order
// - permanent lock only while global bit one
module fcq_host
  import fcq_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // user command port
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic [2:0]        cmd_op,
  input  wire logic [FCQ_AW-1:0] cmd_addr,
  input  wire logic [FCQ_DW-1:0] cmd_data,
  input  wire logic [4:0]        cmd_count,
  input  wire logic [63:0]       cmd_key,
  input  wire logic              word_valid,
  output logic                   word_ready,
  input  wire logic [FCQ_AW-1:0] word_addr,
  input  wire logic [FCQ_DW-1:0] word_data,
  output logic                   rsp_valid,
  output logic                   rsp_error,
  output logic [FCQ_DW-1:0]      rsp_data,
  // flash pins
  output logic [FCQ_AW-1:0]      fl_addr,
  input  wire logic [FCQ_DW-1:0] fl_dq_in,
  output logic [FCQ_DW-1:0]      fl_dq_out,
  output logic                   fl_dq_oe,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n,
  output logic                   fl_rst_n
);

  fcq_state_t        state;
  fcq_op_t           op;
  logic [FCQ_AW-1:0] base;
  logic [FCQ_DW-1:0] wdata;
  logic [4:0]        count;
  logic [63:0]       key;
  logic [4:0]        step;
  logic [4:0]        len;
  logic              is_rd;
  logic              glb_fail;
  logic [3:0]        cnt;
  logic [FCQ_DW-1:0] dq_s1;
  logic [FCQ_DW-1:0] dq_s2;
  logic              st_read;
  logic              st_stream;
  logic [FCQ_AW-1:0] st_addr;
  logic [FCQ_DW-1:0] st_data;
  logic              last_step;

  function automatic logic [FCQ_DW-1:0] key_part(input logic [63:0] k,
                                                 input logic [1:0]  i);
    key_part = k[16*i +: 16];
  endfunction

  // ----------------------------------------------------------------
  // input synchroniser for the data bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end else begin
      dq_s1 <= fl_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // ----------------------------------------------------------------
  // step table: one bus cycle per step
  // ----------------------------------------------------------------
  always_comb begin
    st_read   = 1'b0;
    st_stream = 1'b0;
    st_addr   = ADR_ZERO;
    st_data   = 16'h0000;
    len       = LEN_SINGLE;
    case (op)
      FCQ_OP_READ: begin
        st_read = 1'b1;
        st_addr = base;
      end
      FCQ_OP_WRITE: begin
        st_addr = base;
        st_data = wdata;
      end
      FCQ_OP_BUF_PROG: begin
        len = count + LEN_BUF_XTRA;
        if (step == 5'h00) begin
          st_addr = ADR_UNLOCK1;
          st_data = DAT_UNLOCK1;
        end else if (step == 5'h01) begin
          st_addr = ADR_UNLOCK2;
          st_data = DAT_UNLOCK2;
        end else if (step == 5'h02) begin
          st_addr = base;
          st_data = DAT_BUF_LOAD;
        end else if (step == 5'h03) begin
          st_addr = base;
          st_data = {11'h000, count - 5'h01};
        end else if (step == len - 5'h01) begin
          st_addr = base;
          st_data = DAT_BUF_CONF;
        end else begin
          st_stream = 1'b1;
          st_addr   = word_addr;
          st_data   = word_data;
        end
      end
      FCQ_OP_KEY_PROG: begin
        len = LEN_KEY_PROG;
        // each portion gets its own program command pair
        if (!step[0]) begin
          st_data = DAT_PROGRAM;
        end else begin
          st_addr = {20'h00000, step[2:1]};
          st_data = key_part(key, step[2:1]);
        end
      end
      FCQ_OP_KEY_SUBMIT: begin
        len = LEN_KEY_SUB;
        if (step == 5'h00) begin
          st_data = DAT_BUF_LOAD;
        end else if (step == 5'h01) begin
          st_data = DAT_KEY_CNT;
        end else if (step == 5'h06) begin
          st_data = DAT_BUF_CONF;
        end else begin
          st_addr = {20'h00000, step[1:0] - 2'h2};
          st_data = key_part(key, step[1:0] - 2'h2);
        end
      end
      FCQ_OP_PERM_LOCK: begin
        len = LEN_PERM;
        case (step)
          5'h00, 5'h06: begin
            st_addr = ADR_UNLOCK1;
            st_data = DAT_UNLOCK1;
          end
          5'h01, 5'h07: begin
            st_addr = ADR_UNLOCK2;
            st_data = DAT_UNLOCK2;
          end
          5'h02: begin
            st_addr = ADR_UNLOCK1;
            st_data = DAT_GLB_ENT;
          end
          5'h03: st_read = 1'b1;
          5'h04: st_data = DAT_MODE_EX1;
          5'h08: begin
            st_addr = ADR_UNLOCK1;
            st_data = DAT_PERM_LCK;
          end
          default: st_data = 16'h0000;
        endcase
      end
      FCQ_OP_QUERY: begin
        len = LEN_QUERY;
        if (step == 5'h00) begin
          st_addr = ADR_QUERY;
          st_data = DAT_QRY_ENT;
        end else if (step == 5'h01) begin
          st_read = 1'b1;
          st_addr = base;
        end else begin
          st_data = DAT_ID_EXIT;
        end
      end
      FCQ_OP_ID_EXIT: st_data = DAT_ID_EXIT;
      default: st_data = 16'h0000;
    endcase
  end

  // abandoning the lock after the status read still sends the exit
  assign last_step = (step == len - 5'h01) ||
                     (op == FCQ_OP_PERM_LOCK && step == STEP_GLB_EX &&
                      glb_fail);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state     <= FCQ_IDLE;
      op        <= FCQ_OP_READ;
      base      <= '0;
      wdata     <= 16'h0000;
      count     <= 5'h00;
      key       <= 64'h0;
      step      <= 5'h00;
      is_rd     <= 1'b0;
      glb_fail  <= 1'b0;
      cnt       <= 4'h0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_data  <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        FCQ_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op        <= fcq_op_t'(cmd_op);
            base      <= cmd_addr;
            wdata     <= cmd_data;
            count     <= cmd_count;
            key       <= cmd_key;
            step      <= 5'h00;
            glb_fail  <= 1'b0;
            rsp_error <= 1'b0;
            // refuse a count the buffer cannot hold
            if (fcq_op_t'(cmd_op) == FCQ_OP_BUF_PROG &&
                (cmd_count == 5'h00 || cmd_count > BUF_MAX_WORDS)) begin
              rsp_error <= 1'b1;
              state     <= FCQ_DONE;
            end else begin
              state <= FCQ_FETCH;
            end
          end
        end
        FCQ_FETCH: begin
          if (st_stream && word_valid &&
              word_addr[21:4] != base[21:4]) begin
            rsp_error <= 1'b1;
            state     <= FCQ_DONE;
          end else if (!st_stream || word_valid) begin
            is_rd <= st_read;
            state <= FCQ_SETUP;
          end
        end
        FCQ_SETUP: begin
          cnt   <= is_rd ? ACC_CYC : WP_CYC;
          state <= FCQ_STROBE;
        end
        FCQ_STROBE: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            if (is_rd) begin
              rsp_data <= dq_s2;
              if (op == FCQ_OP_PERM_LOCK && step == STEP_GLB_RD &&
                  !dq_s2[0]) begin
                glb_fail  <= 1'b1;
                rsp_error <= 1'b1;
              end
            end
            state <= FCQ_RECOVER;
          end
        end
        FCQ_RECOVER: begin
          step  <= step + 5'h01;
          state <= last_step ? FCQ_DONE : FCQ_FETCH;
        end
        FCQ_DONE: begin
          rsp_valid <= 1'b1;
          state     <= FCQ_IDLE;
        end
        default: state <= FCQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fl_addr    <= '0;
      fl_dq_out  <= 16'h0000;
      fl_dq_oe   <= 1'b0;
      fl_ce_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
      fl_we_n    <= 1'b1;
      fl_rst_n   <= 1'b0;
      word_ready <= 1'b0;
    end else begin
      fl_rst_n   <= 1'b1;
      word_ready <= 1'b0;
      if (state == FCQ_FETCH && (!st_stream || word_valid) &&
          !(st_stream && word_addr[21:4] != base[21:4])) begin
        fl_addr    <= st_addr;
        fl_dq_out  <= st_data;
        fl_dq_oe   <= !st_read;
        fl_ce_n    <= 1'b0;
        word_ready <= st_stream;
      end else if (state == FCQ_SETUP) begin
        fl_oe_n <= !is_rd;
        fl_we_n <= is_rd;
      end else if (state == FCQ_STROBE && cnt == 4'h1) begin
        // data and address held one cycle past the strobe edge
        fl_oe_n <= 1'b1;
        fl_we_n <= 1'b1;
      end else if (state == FCQ_RECOVER) begin
        fl_ce_n  <= 1'b1;
        fl_dq_oe <= 1'b0;
      end
    end
  end

endmodule

/* File: tb/fcq_host_monitor.sv */
// checker of the host command port and flash pin timing
`timescale 1ns/100ps
module fcq_host_monitor
  import fcq_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic [2:0]        cmd_op,
  input wire logic [FCQ_AW-1:0] cmd_addr,
  input wire logic [4:0]        cmd_count,
  input wire logic              word_valid,
  input wire logic              word_ready,
  input wire logic [FCQ_AW-1:0] word_addr,
  input wire logic              rsp_valid,
  input wire logic              rsp_error,
  input wire logic [FCQ_AW-1:0] fl_addr,
  input wire logic [FCQ_DW-1:0] fl_dq_out,
  input wire logic              fl_dq_oe,
  input wire logic              fl_ce_n,
  input wire logic              fl_oe_n,
  input wire logic              fl_we_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic              take;
  logic [FCQ_AW-1:0] base;
  assign take = cmd_valid && cmd_ready;
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) base <= '0;
    else if (take) base <= cmd_addr;
  sequence s_refused;
    !rsp_valid ##1 rsp_valid && rsp_error;
  endsequence
  sequence s_read;
    (!fl_oe_n && !fl_dq_oe) [*4] ##1 fl_oe_n;
  endsequence
  a_cmd_upper_low:
    assert property (!fl_we_n && (fl_addr[10:0] == 11'h555 ||
      fl_addr[10:0] == 11'h2aa) |-> fl_dq_out[15:8] == 8'h00)
    else $error("command upper byte not low");
  a_strobe_one:
    assert property ($fell(fl_we_n) |=> fl_we_n && !fl_ce_n)
    else $error("write strobe not one cycle");
  a_strobe_framed:
    assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe &&
      $stable(fl_addr) && $stable(fl_dq_out))
    else $error("write strobe outside set-up");
  a_strobe_hold:
    assert property ($rose(fl_we_n) |-> fl_dq_oe && $stable(fl_addr) &&
      $stable(fl_dq_out))
    else $error("write hold broken");
  a_read_four:
    assert property ($fell(fl_oe_n) |-> s_read)
    else $error("read window not four cycles");
  a_count_refused:
    assert property (take && cmd_op == 3'd2 && (cmd_count == 5'h00 ||
      cmd_count > 5'h10) |=> s_refused and fl_ce_n [*2])
    else $error("bad word count not refused");
  a_word_stray:
    assert property (word_valid && !cmd_ready &&
      word_addr[21:4] != base[21:4] |-> ##[0:40] rsp_valid && rsp_error)
    else $error("stray buffered word not refused");
  a_word_match:
    assert property (word_ready |-> $past(word_addr[21:4]) == base[21:4])
    else $error("buffered word taken outside first word row");
  a_rsp_pulse:
    assert property (rsp_valid |=> !rsp_valid && cmd_ready)
    else $error("response not a single pulse");
  a_busy_taken:
    assert property (take |=> !cmd_ready [*2])
    else $error("ready while busy");
endmodule
bind fcq_host fcq_host_monitor u_mon (.clk_sys, .reset_n, .cmd_valid,
  .cmd_ready, .cmd_op, .cmd_addr, .cmd_count, .word_valid, .word_ready,
  .word_addr, .rsp_valid, .rsp_error, .fl_addr, .fl_dq_out, .fl_dq_oe,
  .fl_ce_n, .fl_oe_n, .fl_we_n);

/* File: tb/fcq_flash_model.sv */
// behavioural flash device answering the host pin cycles
`timescale 1ns/100ps
module fcq_flash_model
  import fcq_pkg::*;
#(
  // identification codes: arbitrary values
  parameter logic [15:0] MFR_CODE = 16'h0000,
  parameter logic [15:0] DEV_CODE = 16'h0000
)
(
  input  wire logic [FCQ_AW-1:0] fl_addr,
  input  wire logic [FCQ_DW-1:0] fl_dq_out,
  input  wire logic              fl_ce_n,
  input  wire logic              fl_oe_n,
  input  wire logic              fl_we_n,
  input  wire logic              fl_rst_n,
  input  wire logic              glb_unlocked,
  output logic      [FCQ_DW-1:0] dq_drive
);
  logic [10:0] a, a1, a2;
  logic [7:0]  d, d1, d2;
  logic [2:0]  sub_n;
  logic        qry, glb, perm_seen, key_match, idm;
  logic [15:0] last_wr, wc_seen, last_q, rd;
  logic [15:0] key [4];
  logic [15:0] sub [4];
  assign a = fl_addr[10:0];
  assign d = fl_dq_out[7:0];
  always @(posedge fl_we_n or negedge fl_rst_n) begin
    if (fl_rst_n !== 1'b1) begin
      qry <= 1'b0;
      idm <= 1'b0;
      glb <= 1'b0;
      perm_seen <= 1'b0;
      sub_n <= 3'd0;
      key_match <= 1'b0;
    end else if (!fl_ce_n) begin
      last_wr <= fl_dq_out;
      if (a == 11'h055 && d == 8'h98) qry <= 1'b1;
      if (d == 8'hf0) begin
        qry <= 1'b0;
        idm <= 1'b0;
      end
      // a broken unlock chain enters no identification, global or lock mode
      if (a2 == 11'h555 && d2 == 8'haa && a1 == 11'h2aa && d1 == 8'h55)
      begin
        if (a == 11'h555 && d == 8'h90) idm <= 1'b1;
        if (a == 11'h555 && d == 8'h50) glb <= 1'b1;
        if (a == 11'h555 && d == 8'h87) perm_seen <= 1'b1;
      end
      if (glb && d == 8'h90) glb <= 1'b0;
      if (d1 == 8'h25) wc_seen <= fl_dq_out;
      if (d1 == 8'ha0) key[fl_addr[1:0]] <= fl_dq_out;
      if (d1 == 8'h25 && d == 8'h03) sub_n <= 3'd4;
      else if (sub_n != 3'd0) begin
        sub[fl_addr[1:0]] <= fl_dq_out;
        sub_n <= sub_n - 3'd1;
      end else if (d == 8'h29) key_match <= (sub == key);
      a2 <= a1;
      d2 <= d1;
      a1 <= a;
      d1 <= d;
    end
  end
  always_comb begin
    case (fl_addr[7:0])
      8'h10: rd = 16'h0051;
      8'h11: rd = 16'h0052;
      8'h12: rd = 16'h0059;
      8'h13: rd = 16'h0002;
      8'h15: rd = 16'h0040;
      8'h1b: rd = 16'h0027;
      8'h1c: rd = 16'h0036;
      8'h1f, 8'h20: rd = 16'h0003;
      8'h21: rd = 16'h0004;
      8'h22: rd = 16'h0005;
      8'h23, 8'h25, 8'h26: rd = 16'h0001;
      8'h24: rd = 16'h0003;
      default: rd = 16'h0000;
    endcase
    if (!qry && idm) begin
      if (fl_addr[7:0] == 8'hff) rd = 16'h0008;
      else if (fl_addr[21:1] != 21'h0) rd = DEV_CODE;
      else rd = fl_addr[0] ? DEV_CODE : MFR_CODE;
    end else if (!qry && glb) begin
      rd = {15'h0, glb_unlocked};
    end else if (!qry) begin
      rd = fl_addr[15:0] ^ 16'h5a5a;
    end
  end
  // released bus shows the inverse so stale data never passes
  always @(posedge fl_oe_n) last_q <= rd;
  assign dq_drive = (!fl_ce_n && !fl_oe_n) ? rd : ~last_q;
endmodule

/* File: tb/fcq_host_tb.sv */
// self-checking bench for the flash host sequencer
`timescale 1ns/100ps
module fcq_host_tb
  import fcq_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              word_valid = 1'b0;
  logic              glb_unlocked = 1'b0;
  logic              cmd_ready, word_ready, rsp_valid, rsp_error;
  logic              fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n;
  logic [2:0]        cmd_op = 3'h0;
  logic [4:0]        cmd_count = 5'h00;
  logic [63:0]       cmd_key = '0;
  logic [FCQ_AW-1:0] cmd_addr = '0, word_addr = '0, fl_addr;
  logic [FCQ_DW-1:0] cmd_data = '0, word_data = '0, rsp_data;
  logic [FCQ_DW-1:0] fl_dq_out, dq_drive, fl_dq_in;
  int                errors = 0;
  int                checks_done = 0;
  // identification codes: arbitrary values
  localparam logic [15:0] ID_MFR = 16'h0a5c;
  localparam logic [15:0] ID_DEV = 16'h0c3a;
  localparam logic [15:0] EXP_Q [23] = '{16'h0051, 16'h0052, 16'h0059,
    16'h0002, 16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0027, 16'h0036, 16'h0000, 16'h0000, 16'h0003, 16'h0003,
    16'h0004, 16'h0005, 16'h0001, 16'h0003, 16'h0001, 16'h0001};
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : dq_drive;
  fcq_host dut (.clk_sys, .reset_n, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_data, .cmd_count, .cmd_key, .word_valid, .word_ready,
    .word_addr, .word_data, .rsp_valid, .rsp_error, .rsp_data, .fl_addr,
    .fl_dq_in, .fl_dq_out, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n,
    .fl_rst_n);
  fcq_flash_model #(.MFR_CODE(ID_MFR), .DEV_CODE(ID_DEV)) u_flash (
    .fl_addr, .fl_dq_out, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_rst_n,
    .glb_unlocked, .dq_drive);
  initial forever #25 clk_sys = ~clk_sys;
  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0, got}, {15'h0, exp});
  endtask
  task automatic run_cmd(input logic [2:0] op, input logic [21:0] adr,
                         input logic [4:0] cnt);
    int n;
    @(negedge clk_sys);
    cmd_op = op;
    cmd_addr = adr;
    cmd_count = cnt;
    cmd_valid = 1'b1;
    for (n = 0; cmd_ready !== 1'b1 && n < 100; n++) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1 && n < 400; n++) @(negedge clk_sys);
    if (n == 400) errors++;
  endtask
  // unlock pair then identification entry, as three plain writes
  task automatic id_enter();
    cmd_data = 16'h00aa;
    run_cmd(3'd1, 22'h000555, 5'h00);
    cmd_data = 16'h0055;
    run_cmd(3'd1, 22'h0002aa, 5'h00);
    cmd_data = 16'h0090;
    run_cmd(3'd1, 22'h000555, 5'h00);
  endtask
  // words stay offered until taken; a stray last word may never be taken
  task automatic feed(input int num, input logic bad);
    int n;
    @(negedge clk_sys);
    for (int i = 0; i < num; i++) begin
      word_addr = (bad && i == num - 1) ? 22'h012350 : 22'h012340 + 22'(i);
      word_data = 16'h1200 + 16'(i);
      word_valid = 1'b1;
      n = 0;
      do @(negedge clk_sys); while (word_ready !== 1'b1 && ++n < 200);
    end
    word_valid = 1'b0;
  endtask
  initial begin
    #(20000 * 50);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    cmd_data = 16'h00c3;
    run_cmd(3'd1, 22'h000100, 5'h00);
    chk_val(u_flash.last_wr, 16'h00c3);
    run_cmd(3'd0, 22'h003456, 5'h00);
    chk_val(rsp_data, 16'h3456 ^ 16'h5a5a);
    for (int i = 0; i < 23; i++) begin
      run_cmd(3'd6, 22'h000010 + 22'(i), 5'h00);
      chk_val(rsp_data, EXP_Q[i]);
    end
    id_enter();
    run_cmd(3'd0, 22'h000000, 5'h00);
    chk_val(rsp_data, ID_MFR);
    run_cmd(3'd0, 22'h000001, 5'h00);
    chk_val(rsp_data, ID_DEV);
    run_cmd(3'd0, 22'h0000ff, 5'h00);
    chk_val(rsp_data, 16'h0008);
    // mid-run reset must drop the device out of identification mode
    @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    run_cmd(3'd0, 22'h000000, 5'h00);
    chk_val(rsp_data, 16'h5a5a);
    id_enter();
    run_cmd(3'd7, 22'h000000, 5'h00);
    run_cmd(3'd0, 22'h000011, 5'h00);
    chk_val(rsp_data, 16'h0011 ^ 16'h5a5a);
    for (int c = 1; c <= 16; c += 15) begin
      fork
        run_cmd(3'd2, 22'h012340, 5'(c));
        feed(c, 1'b0);
      join
      chk_val(u_flash.wc_seen, 16'(c - 1));
      chk_bit(rsp_error, 1'b0);
    end
    run_cmd(3'd2, 22'h012340, 5'h00);
    chk_bit(rsp_error, 1'b1);
    run_cmd(3'd2, 22'h012340, 5'h11);
    chk_bit(rsp_error, 1'b1);
    fork
      run_cmd(3'd2, 22'h012340, 5'h02);
      feed(2, 1'b1);
    join
    chk_bit(rsp_error, 1'b1);
    cmd_key = 64'h4444_3333_2222_1111;
    run_cmd(3'd3, 22'h000000, 5'h00);
    chk_val(u_flash.key[2], 16'h3333);
    run_cmd(3'd4, 22'h000000, 5'h00);
    chk_bit(u_flash.key_match, 1'b1);
    cmd_key = 64'h4444_3333_2222_1112;
    run_cmd(3'd4, 22'h000000, 5'h00);
    chk_bit(u_flash.key_match, 1'b0);
    run_cmd(3'd5, 22'h000000, 5'h00);
    chk_bit(rsp_error, 1'b1);
    chk_val(rsp_data, 16'h0000);
    chk_bit(u_flash.perm_seen, 1'b0);
    glb_unlocked = 1'b1;
    run_cmd(3'd5, 22'h000000, 5'h00);
    chk_bit(rsp_error, 1'b0);
    chk_val(rsp_data, 16'h0001);
    chk_bit(u_flash.perm_seen, 1'b1);
    tally_and_finish();
  end
endmodule
